//--- rtl/scs_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - With auto calibration on, stillness beyond 7.5 s reloads the gyro bias from the sample.
// - A manual calibration command runs a bias calibration of 30 s, then normal output resumes.
// - With the threshold on, motion samples slower than the set limit are dropped.
// - No command starts a magnetometer calibration; such a request gets a NACK.
// - Command 83 from the host arms the timestamp reset.
// - While armed the green indicator blinks at 4 Hz.
// - An armed low-going sync clears the timestamp within 2.5 ms.
// - The timestamp wraps to zero after 10737418.2375 s.
// - Sampling and processing run on a fixed 400 Hz frame tick.
// - Only the host starts transactions, either read or write; this block only answers.
// - A read request normally has no data and is answered with the data asked for.
// - Each write is answered with an acknowledge on success, else a negative acknowledge.
// - Frames are start byte, id, command, length, data, checksum, CR LF, low bytes first.
// - The checksum is the 16-bit sum of id, command, length and data bytes; mismatch is an error.
module scs_ctrl
  import scs_pkg::*;
#(
  parameter int TICK_CYC_P = TICK_CYC,
  parameter int LED_HALF_P = LED_HALF_CYC,
  parameter logic [15:0] SENSOR_ID_P = SENSOR_ID_DEF
)
(
  input wire logic ref_clk, // 20 MHz clock
  input wire logic rst_n, // async reset
  input wire logic rx_valid, // host byte strobe
  input wire logic [7:0] rx_data, // host byte
  input wire logic tx_ready, // link takes byte
  output logic tx_valid, // reply byte offered
  output logic [7:0] tx_data, // reply byte
  input wire logic sync_n, // external sync line
  input wire logic [15:0] gyro_in, // raw gyro rate
  output logic [15:0] gyro_bias, // bias offset
  output logic motion_valid, // processed sample
  output logic [15:0] motion_data, // bias-corrected rate
  output logic cal_busy, // manual calibration
  output logic [31:0] timestamp, // frame count
  output logic frame_tick, // 400 Hz pulse
  output logic led_green, // status indicator
  output logic pkt_err // bad frame pulse
);
  localparam int TW = $clog2(TICK_CYC_P);
  localparam int LW = $clog2(LED_HALF_P);

  scs_if link();

  logic [TW-1:0] tick_cnt;
  logic [LW-1:0] led_cnt;
  logic led_blink;
  logic armed;
  logic sync_m, sync_s, sync_d;
  logic auto_en, thr_en;
  logic [15:0] thr_lim;
  logic [11:0] still_cnt;
  logic [13:0] cal_cnt;
  logic pend;
  logic [15:0] p_cmd, p_len;
  logic [31:0] p_data;

  // ------------------------------------------------------------
  // packet engines
  // ------------------------------------------------------------
  scs_rx u_rx (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .sensor_id(SENSOR_ID_P),
    .pkt_err(pkt_err),
    .bus(link.rx_mp)
  );

  scs_tx u_tx (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sensor_id(SENSOR_ID_P),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .bus(link.tx_mp)
  );

  // ------------------------------------------------------------
  // frame tick and timestamp
  // ------------------------------------------------------------
  wire tick = (tick_cnt == TW'(TICK_CYC_P - 1));
  wire sync_fall = sync_d && !sync_s;
  wire ts_fire = armed && sync_fall;
  wire [31:0] next_ts = (timestamp == TS_WRAP) ? 32'h00000000 : timestamp + 32'h00000001;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt <= '0;
    else
      tick_cnt <= tick ? '0 : tick_cnt + TW'(1);
  end

  // clear beats the frame count; done in a few cycles, far inside 2.5 ms
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      timestamp <= 32'h00000000;
    else if (ts_fire)
      timestamp <= 32'h00000000;
    else if (tick)
      timestamp <= next_ts;
  end

  // ------------------------------------------------------------
  // sync line and arm state
  // ------------------------------------------------------------
  // first stage feeds only the second; edge taken from later stages
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      {sync_m, sync_s, sync_d} <= 3'h7;
    else
      {sync_m, sync_s, sync_d} <= {sync_n, sync_m, sync_s};
  end

  wire cmd_take = pend && link.rsp_ready;
  wire arm_cmd = cmd_take && (p_cmd == CMD_ARM_TS);

  // a fresh arm in the firing cycle wins over the disarm
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      armed <= 1'b0;
    else if (arm_cmd)
      armed <= 1'b1;
    else if (ts_fire)
      armed <= 1'b0;
  end

  // ------------------------------------------------------------
  // status indicator: steady on, blinking while armed
  // ------------------------------------------------------------
  wire led_flip = (led_cnt == LW'(LED_HALF_P - 1));

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      led_cnt <= '0;
      led_blink <= 1'b1;
      led_green <= 1'b1;
    end
    else
    begin
      led_cnt <= (!armed || led_flip) ? '0 : led_cnt + LW'(1);
      led_blink <= !armed ? 1'b1 : (led_flip ? !led_blink : led_blink);
      led_green <= !armed || led_blink;
    end
  end

  // ------------------------------------------------------------
  // gyro bias calibration and threshold
  // ------------------------------------------------------------
  wire [15:0] corr = gyro_in - gyro_bias;
  wire [15:0] corr_mag = corr[15] ? 16'(-corr) : corr;
  wire still = corr_mag < STILL_LIM;
  wire auto_hit = auto_en && still && (still_cnt == AUTO_TICKS);
  wire cal_end = cal_busy && (cal_cnt == MAN_TICKS - 14'h0001);
  wire bias_load = tick && (auto_hit || cal_end);
  wire thr_drop = thr_en && (corr_mag < thr_lim);
  wire cal_start = cmd_take && (p_cmd == CMD_START_CAL) && !cal_busy;

  // stillness counted in frames; motion restarts the wait
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      still_cnt <= 12'h000;
    else if (tick)
      still_cnt <= (!auto_en || !still || auto_hit) ? 12'h000 : still_cnt + 12'h001;
  end

  // manual run holds output for the whole window
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cal_busy <= 1'b0;
      cal_cnt <= 14'h0000;
    end
    else if (cal_start)
    begin
      cal_busy <= 1'b1;
      cal_cnt <= 14'h0000;
    end
    else if (tick && cal_busy)
    begin
      cal_busy <= !cal_end;
      cal_cnt <= cal_cnt + 14'h0001;
    end
  end

  // bias is the single sample at the end; no averaging is done
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      gyro_bias <= 16'h0000;
    else if (bias_load)
      gyro_bias <= gyro_in;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      motion_valid <= 1'b0;
      motion_data <= 16'h0000;
      frame_tick <= 1'b0;
    end
    else
    begin
      frame_tick <= tick;
      motion_valid <= tick && !cal_busy && !thr_drop;
      if (tick)
        motion_data <= corr;
    end
  end

  // ------------------------------------------------------------
  // request decode and reply
  // ------------------------------------------------------------
  wire is_get = (p_cmd == CMD_GET_TS) || (p_cmd == CMD_GET_STATUS) ||
                (p_cmd == CMD_GET_BIAS);
  // unknown numbers, magnetometer calibration among them, get a NACK
  wire set_ok = (p_cmd == CMD_ARM_TS) ||
                ((p_cmd == CMD_START_CAL) && !cal_busy) ||
                ((p_cmd == CMD_SET_AUTO) && (p_len >= LEN_BYTE)) ||
                ((p_cmd == CMD_SET_THR_EN) && (p_len >= LEN_BYTE)) ||
                ((p_cmd == CMD_SET_THR_LIM) && (p_len >= LEN_HALF));
  wire [31:0] status = {28'h0000000, armed, cal_busy, thr_en, auto_en};
  wire [31:0] get_word = (p_cmd == CMD_GET_TS) ? timestamp :
                         (p_cmd == CMD_GET_STATUS) ? status : {16'h0000, gyro_bias};

  assign link.rsp_valid = pend;
  assign link.rsp_cmd = is_get ? p_cmd : (set_ok ? CMD_ACK : CMD_NACK);
  assign link.rsp_len = is_get ? LEN_WORD : LEN_NONE;
  assign link.rsp_data = is_get ? get_word : 32'h00000000;

  // one request held at a time; a request while one is still pending is dropped
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend <= 1'b0;
      {p_cmd, p_len, p_data} <= '0;
    end
    else if (link.req_valid && !pend)
    begin
      pend <= 1'b1;
      {p_cmd, p_len, p_data} <= {link.req_cmd, link.req_len, link.req_data};
    end
    else if (cmd_take)
      pend <= 1'b0;
  end

  // writes land when the reply is accepted
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      auto_en <= AUTO_EN_RST;
      thr_en <= THR_EN_RST;
      thr_lim <= THR_LIM_RST;
    end
    else if (cmd_take && set_ok)
    begin
      if (p_cmd == CMD_SET_AUTO)
        auto_en <= p_data[0];
      if (p_cmd == CMD_SET_THR_EN)
        thr_en <= p_data[0];
      if (p_cmd == CMD_SET_THR_LIM)
        thr_lim <= p_data[15:0];
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_ts_clear_fire: assert property (ts_fire && !arm_cmd |=>
    timestamp == 32'h00000000 && !armed)
    else $error("timestamp not cleared by armed sync");
  a_ts_frame_step: assert property (tick && !ts_fire |=> timestamp == $past(next_ts))
    else $error("timestamp did not step on frame");
  a_tick_gap: assert property (tick |=> !tick [*8])
    else $error("frame tick too close");
  a_arm_set: assert property (arm_cmd |=> armed ##1 (armed || $past(ts_fire)))
    else $error("arm command not held");
  a_led_steady: assert property (!armed ##1 !armed |-> led_green)
    else $error("indicator not steady while disarmed");
  a_sync_edge: assert property (armed && $fell(sync_m) |-> !ts_fire ##1 ts_fire)
    else $error("sync edge not taken one stage later");
  a_thr_drop: assert property (tick && thr_drop |=> !motion_valid)
    else $error("sub-threshold sample passed");
  a_bias_load: assert property (bias_load |=> gyro_bias == $past(gyro_in))
    else $error("bias not reloaded");
  a_cal_end: assert property (tick && cal_end |=> !cal_busy)
    else $error("manual calibration did not end");
  a_set_reply: assert property (pend && !is_get |-> link.rsp_len == LEN_NONE &&
    (link.rsp_cmd == (set_ok ? CMD_ACK : CMD_NACK)))
    else $error("write reply wrong");
  a_get_reply: assert property (pend && is_get |-> link.rsp_len == LEN_WORD)
    else $error("read reply length wrong");

  c_arm_fire: cover property (arm_cmd ##[1:200] ts_fire);
  c_cal_run: cover property (cal_start ##1 cal_busy);
  c_nack: cover property (cmd_take && !is_get && !set_ok);
endmodule : scs_ctrl

//--- common/scs_pkg.sv
package scs_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int TICK_HZ = 400;
  localparam int TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int AUTO_STILL_MS = 7500;
  localparam logic [11:0] AUTO_TICKS = 12'(AUTO_STILL_MS * TICK_HZ / 1000);
  localparam int MAN_CAL_S = 30;
  localparam logic [13:0] MAN_TICKS = 14'(MAN_CAL_S * TICK_HZ);
  localparam int LED_HZ = 4;
  localparam int LED_HALF_CYC = CLK_HZ / (2 * LED_HZ);
  localparam int TS_RST_MAX_US = 2500;
  localparam int TS_RST_MAX_CYC = TS_RST_MAX_US * (CLK_HZ / 1000000);
  // 2.5 ms frames: full count equals 10737418.2375 s
  localparam logic [31:0] TS_WRAP = 32'hffffffff;

  // ------------------------------------------------------------
  // packet framing and commands
  // ------------------------------------------------------------
  localparam logic [7:0] PKT_SOF = 8'h3a;
  localparam logic [7:0] PKT_EOF1 = 8'h0d;
  localparam logic [7:0] PKT_EOF2 = 8'h0a;
  localparam logic [15:0] SENSOR_ID_DEF = 16'h0001;
  localparam logic [15:0] LEN_NONE = 16'h0000;
  localparam logic [15:0] LEN_BYTE = 16'h0001;
  localparam logic [15:0] LEN_HALF = 16'h0002;
  localparam logic [15:0] LEN_WORD = 16'h0004;
  localparam logic [15:0] CMD_ACK = 16'h0000;
  localparam logic [15:0] CMD_NACK = 16'h0001;
  localparam logic [15:0] CMD_START_CAL = 16'h0004;
  localparam logic [15:0] CMD_SET_AUTO = 16'h0005;
  localparam logic [15:0] CMD_SET_THR_EN = 16'h0006;
  localparam logic [15:0] CMD_SET_THR_LIM = 16'h0007;
  localparam logic [15:0] CMD_GET_TS = 16'h0008;
  localparam logic [15:0] CMD_GET_STATUS = 16'h0009;
  localparam logic [15:0] CMD_GET_BIAS = 16'h000a;
  localparam logic [15:0] CMD_ARM_TS = 16'h0053;

  // ------------------------------------------------------------
  // motion thresholds and reset values
  // ------------------------------------------------------------
  localparam logic [15:0] STILL_LIM = 16'h0040;
  localparam logic [15:0] THR_LIM_RST = 16'h0020;
  localparam logic AUTO_EN_RST = 1'b1;
  localparam logic THR_EN_RST = 1'b0;

  typedef enum logic [11:0] {
    RX_IDLE = 12'h001, RX_ID0 = 12'h002, RX_ID1 = 12'h004,
    RX_CM0 = 12'h008, RX_CM1 = 12'h010, RX_LN0 = 12'h020,
    RX_LN1 = 12'h040, RX_DAT = 12'h080, RX_CK0 = 12'h100,
    RX_CK1 = 12'h200, RX_T0 = 12'h400, RX_T1 = 12'h800
  } scs_rx_state_t;
endpackage : scs_pkg

//--- common/scs_if.sv
`timescale 1ns/1ps
interface scs_if;
  logic req_valid;
  logic [15:0] req_cmd;
  logic [15:0] req_len;
  logic [31:0] req_data;
  logic rsp_valid;
  logic rsp_ready;
  logic [15:0] rsp_cmd;
  logic [15:0] rsp_len;
  logic [31:0] rsp_data;
  modport rx_mp(output req_valid, req_cmd, req_len, req_data);
  modport core_mp(input req_valid, req_cmd, req_len, req_data, rsp_ready,
                  output rsp_valid, rsp_cmd, rsp_len, rsp_data);
  modport tx_mp(input rsp_valid, rsp_cmd, rsp_len, rsp_data, output rsp_ready);
endinterface : scs_if

//--- rtl/scs_rx.sv
`timescale 1ns/1ps
module scs_rx
  import scs_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset
  input wire logic rx_valid, // byte strobe
  input wire logic [7:0] rx_data, // received byte
  input wire logic [15:0] sensor_id, // own address
  output logic pkt_err, // bad frame pulse
  scs_if.rx_mp bus // parsed request
);
  scs_rx_state_t state, next_state;
  logic [15:0] id, cmd, len, cnt, sum, ck;
  logic [31:0] data;
  wire [15:0] word = {rx_data, ck[7:0]};
  wire data_last = (cnt == len - LEN_BYTE);
  wire sum_ok = ({rx_data, ck[7:0]} == sum);

  // ------------------------------------------------------------
  // frame walk
  // ------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    if (rx_valid)
    begin
      unique case (state)
        RX_IDLE: next_state = (rx_data == PKT_SOF) ? RX_ID0 : RX_IDLE;
        RX_ID0: next_state = RX_ID1;
        RX_ID1: next_state = RX_CM0;
        RX_CM0: next_state = RX_CM1;
        RX_CM1: next_state = RX_LN0;
        RX_LN0: next_state = RX_LN1;
        RX_LN1: next_state = (word == LEN_NONE) ? RX_CK0 : RX_DAT;
        RX_DAT: next_state = data_last ? RX_CK0 : RX_DAT;
        RX_CK0: next_state = RX_CK1;
        RX_CK1: next_state = RX_T0;
        RX_T0: next_state = (rx_data == PKT_EOF1) ? RX_T1 : RX_IDLE;
        RX_T1: next_state = RX_IDLE;
        default: next_state = RX_IDLE;
      endcase
    end
  end

  // fields, running sum of 16-bit words and data bytes
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= RX_IDLE;
      {id, cmd, len, cnt, sum, ck, data} <= '0;
      bus.req_valid <= 1'b0;
      pkt_err <= 1'b0;
    end
    else
    begin
      state <= next_state;
      bus.req_valid <= 1'b0;
      pkt_err <= 1'b0;
      if (rx_valid)
      begin
        ck[7:0] <= rx_data;
        unique case (state)
          RX_IDLE: {sum, cnt, data} <= '0;
          RX_ID1: {id, sum} <= {word, sum + word};
          RX_CM1: {cmd, sum} <= {word, sum + word};
          RX_LN1: {len, sum} <= {word, sum + word};
          RX_DAT:
          begin
            sum <= sum + {8'h00, rx_data};
            cnt <= cnt + LEN_BYTE;
            if (cnt < LEN_WORD)
              data[cnt[1:0]*8 +: 8] <= rx_data;
          end
          RX_CK1: ck <= {7'h00, sum_ok, 8'h00};
          RX_T0: pkt_err <= (rx_data != PKT_EOF1);
          RX_T1:
          begin
            // checksum mismatch is reported, frame dropped
            pkt_err <= (rx_data != PKT_EOF2) || !ck[8];
            bus.req_valid <= (rx_data == PKT_EOF2) && ck[8] && (id == sensor_id);
          end
          default: ;
        endcase
      end
    end
  end

  assign bus.req_cmd = cmd;
  assign bus.req_len = len;
  assign bus.req_data = data;
endmodule : scs_rx

//--- rtl/scs_tx.sv
`timescale 1ns/1ps
module scs_tx
  import scs_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset
  input wire logic [15:0] sensor_id, // own address
  input wire logic tx_ready, // sink takes byte
  output logic tx_valid, // byte offered
  output logic [7:0] tx_data, // byte out
  scs_if.tx_mp bus // response to send
);
  logic busy;
  logic [4:0] idx;
  logic [15:0] cmd, len, ck;
  logic [31:0] data;
  logic [7:0] next_byte;
  wire [4:0] len5 = len[4:0];
  wire [4:0] nidx = idx + 5'h01;
  wire [4:0] last = len5 + 5'h0a;
  wire take = bus.rsp_valid && !busy;
  // checksum over id, command, length and the data bytes sent
  wire [15:0] dsum = (bus.rsp_len == LEN_WORD) ?
    16'(bus.rsp_data[7:0]) + 16'(bus.rsp_data[15:8]) +
    16'(bus.rsp_data[23:16]) + 16'(bus.rsp_data[31:24]) : 16'h0000;
  wire [15:0] next_ck = sensor_id + bus.rsp_cmd + bus.rsp_len + dsum;

  assign bus.rsp_ready = !busy;
  assign tx_valid = busy;

  // ------------------------------------------------------------
  // byte order: low byte first
  // ------------------------------------------------------------
  always_comb
  begin
    next_byte = PKT_EOF2;
    if (nidx < 5'h07)
      next_byte = (nidx[0] ? (nidx == 5'h01 ? sensor_id[7:0] : nidx == 5'h03 ?
        cmd[7:0] : len[7:0]) : (nidx == 5'h02 ? sensor_id[15:8] : nidx == 5'h04 ?
        cmd[15:8] : len[15:8]));
    else if (nidx < 5'h07 + len5)
      next_byte = data[(nidx - 5'h07)*8 +: 8];
    else if (nidx - len5 == 5'h07)
      next_byte = ck[7:0];
    else if (nidx - len5 == 5'h08)
      next_byte = ck[15:8];
    else if (nidx - len5 == 5'h09)
      next_byte = PKT_EOF1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {busy, idx, cmd, len, ck, data} <= '0;
      tx_data <= 8'h00;
    end
    else if (take)
    begin
      {busy, idx, tx_data} <= {1'b1, 5'h00, PKT_SOF};
      {cmd, len, ck, data} <= {bus.rsp_cmd, bus.rsp_len, next_ck, bus.rsp_data};
    end
    else if (busy && tx_ready)
    begin
      busy <= (idx != last);
      idx <= nidx;
      tx_data <= next_byte;
    end
  end
endmodule : scs_tx

//--- sim/scs_host.sv
`timescale 1ns/1ps
// host end of the byte link: sends requests, gathers reply bytes
module scs_host
  import scs_pkg::*;
(
  input wire logic ref_clk, // system clock
  output logic rx_valid, // byte strobe to device
  output logic [7:0] rx_data, // byte to device
  output logic tx_ready, // reply sink ready
  input wire logic tx_valid, // device offers byte
  input wire logic [7:0] tx_data // device byte
);
  logic [7:0] got[$]; // reply bytes in arrival order
  logic slow = 1'b0; // stalls the reply side
  // idle link at time zero
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end
  // a byte counts only on an accepting edge
  always @(posedge ref_clk)
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      got.push_back(tx_data);
  // slow mode drops ready every other cycle
  always @(negedge ref_clk)
    tx_ready <= slow ? ~tx_ready : 1'b1;
  // whole frame, low bytes first; the fault flips one checksum bit
  task automatic request(input logic [15:0] cmd, input logic [15:0] len,
                         input logic [31:0] data, input logic bad);
    logic [7:0] f[$];
    logic [15:0] ck;
    ck = SENSOR_ID_DEF + cmd + len;
    f = {PKT_SOF, SENSOR_ID_DEF[7:0], SENSOR_ID_DEF[15:8], cmd[7:0], cmd[15:8],
         len[7:0], len[15:8]};
    for (int k = 0; k < int'(len) && k < 4; k++)
    begin
      f.push_back(data[8*k+:8]);
      ck = ck + 16'(data[8*k+:8]);
    end
    ck = bad ? ck ^ 16'h0100 : ck;
    f = {f, ck[7:0], ck[15:8], PKT_EOF1, PKT_EOF2};
    foreach (f[i])
    begin
      @(negedge ref_clk);
      rx_valid <= 1'b1;
      rx_data <= f[i];
    end
    @(negedge ref_clk);
    rx_valid <= 1'b0;
    // released line must not look like a stale byte
    rx_data <= ~f[f.size()-1];
  endtask : request
endmodule : scs_host

//--- sim/scs_ctrl_tb.sv
`timescale 1ns/1ps
module scs_ctrl_tb
  import scs_pkg::*;
;
  localparam int TK = 20; // short frame keeps the run brief
  localparam int LH = 8; // short blink half period
  localparam logic [15:0] TC [7] = '{CMD_SET_AUTO, CMD_SET_THR_EN, CMD_SET_THR_LIM,
    CMD_SET_THR_EN, 16'h00ff, CMD_GET_BIAS, CMD_GET_STATUS};
  localparam logic [15:0] TL [7] = '{LEN_BYTE, LEN_BYTE, LEN_HALF, LEN_NONE, LEN_NONE,
    LEN_NONE, LEN_NONE};
  localparam logic [15:0] TR [7] = '{CMD_ACK, CMD_ACK, CMD_ACK, CMD_NACK, CMD_NACK,
    CMD_GET_BIAS, CMD_GET_STATUS};
  // data sent, or expected back for the two reads
  localparam logic [31:0] TD [7] = '{32'h0, 32'h1, 32'h30, 32'h1, 32'h0, 32'h0, 32'h2};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sync_n = 1'b1;
  logic [15:0] gyro_in = 16'h0000;
  logic rx_valid, tx_ready, tx_valid, motion_valid, cal_busy, frame_tick, led_green, pkt_err, lp;
  logic [7:0] rx_data, tx_data;
  logic [15:0] gyro_bias, motion_data;
  logic [31:0] timestamp, d, e;
  logic [31:0] seed = 32'hd88bcb2b;
  time t0;
  int n_errors = 0;
  int checks = 0;
  int cnt, w;
  // clock toggles every half period
  always #25 ref_clk = ~ref_clk;
  scs_ctrl #(.TICK_CYC_P(TK), .LED_HALF_P(LH)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .sync_n(sync_n), .gyro_in(gyro_in), .gyro_bias(gyro_bias),
    .motion_valid(motion_valid), .motion_data(motion_data), .cal_busy(cal_busy),
    .timestamp(timestamp), .frame_tick(frame_tick), .led_green(led_green), .pkt_err(pkt_err));
  scs_host host_u (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val
  task automatic close_out();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // bounded wait for the frame pulse, returns cycles waited
  task automatic wait_tick(output int n);
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (frame_tick !== 1'b1 && n < 4 * TK);
  endtask : wait_tick
  // one request, whole reply frame checked against the model
  task automatic xfer(input logic [15:0] cmd, len, input logic [31:0] data,
                      input logic [15:0] rcmd, rlen, output logic [31:0] rd);
    logic [7:0] b[$];
    logic [15:0] ck;
    int n;
    host_u.request(cmd, len, data, 1'b0);
    n = 0;
    while (host_u.got.size() < 11 + int'(rlen) && n < 600)
    begin
      @(negedge ref_clk);
      n++;
    end
    repeat (2) @(negedge ref_clk);
    b = host_u.got;
    host_u.got.delete();
    rd = 32'h0;
    n = int'(rlen);
    chk_val(b.size(), 11 + n, "reply size");
    if (b.size() != 11 + n) return;
    ck = SENSOR_ID_DEF + rcmd + rlen;
    for (int k = 0; k < n; k++)
    begin
      rd[8*k+:8] = b[7+k];
      ck = ck + 16'(b[7+k]);
    end
    chk_val({b[0], b[6], b[5]}, {PKT_SOF, rlen}, "start and length");
    chk_val({b[2], b[1], b[4], b[3]}, {SENSOR_ID_DEF, rcmd}, "id and command");
    chk_val({b[8+n], b[7+n], b[9+n], b[10+n]}, {ck, PKT_EOF1, PKT_EOF2}, "tail");
  endtask : xfer
  // pulses in one frame-long window, each checked for a bias-free value
  task automatic motion_count(output int c);
    c = 0;
    repeat (TK)
    begin
      @(negedge ref_clk);
      if (motion_valid === 1'b1)
      begin
        c++;
        chk_val(motion_data, gyro_in, "motion data");
      end
    end
  endtask : motion_count
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (4) @(negedge ref_clk);
    rst_n <= 1'b1;
    t0 = $time;
    chk_val({gyro_bias, tx_valid, cal_busy, led_green, timestamp[0]}, 32'h2, "reset");
    wait_tick(w);
    d = timestamp;
    wait_tick(w);
    chk_val({w, timestamp - d}, {TK, 32'h1}, "frame spacing");
    xfer(CMD_GET_TS, LEN_NONE, 32'h0, CMD_GET_TS, LEN_WORD, d);
    e = 32'(($time - t0) / (50 * TK));
    chk_val(32'(e - d <= 32'h2), 32'h1, "timestamp read");
    host_u.slow = 1'b1;
    foreach (TC[i])
    begin
      xfer(TC[i], TL[i], TD[i], TR[i], (TR[i] == TC[i]) ? LEN_WORD : LEN_NONE, d);
      if (TR[i] == TC[i])
        chk_val(d, TD[i], "read data");
    end
    host_u.slow = 1'b0;
    // corrupt checksum: error pulse and silence
    host_u.request(CMD_GET_TS, LEN_NONE, 32'h0, 1'b1);
    // the pulse already stands when the task returns
    cnt = int'(pkt_err === 1'b1);
    repeat (40)
    begin
      @(negedge ref_clk);
      cnt += (pkt_err === 1'b1);
    end
    chk_val({cnt, host_u.got.size()}, {32'h1, 32'h0}, "checksum fault");
    // random slow and fast rates against the speed limit
    repeat (12)
    begin
      gyro_in <= 16'(rnd() % 32'h80) - 16'h0040;
      wait_tick(w);
      wait_tick(w);
      motion_count(cnt);
      chk_val(cnt, (gyro_in[15] ? 16'(-gyro_in) : gyro_in) >= 16'h0030, "drop");
    end
    xfer(CMD_ARM_TS, LEN_NONE, 32'h0, CMD_ACK, LEN_NONE, d);
    repeat (LH) @(negedge ref_clk);
    cnt = 0;
    lp = led_green;
    repeat (4 * LH)
    begin
      @(negedge ref_clk);
      cnt += (led_green !== lp);
      lp = led_green;
    end
    chk_val(cnt, 4, "blink count");
    xfer(CMD_GET_STATUS, LEN_NONE, 32'h0, CMD_GET_STATUS, LEN_WORD, d);
    chk_val(d, 32'ha, "armed status");
    wait_tick(w);
    sync_n <= 1'b0;
    repeat (4) @(negedge ref_clk);
    chk_val(timestamp, 32'h0, "sync clear");
    sync_n <= 1'b1;
    xfer(CMD_GET_STATUS, LEN_NONE, 32'h0, CMD_GET_STATUS, LEN_WORD, d);
    chk_val({d, led_green}, {32'h2, 1'b1}, "disarmed");
    // a fall while disarmed must leave the count alone
    sync_n <= 1'b0;
    repeat (4) @(negedge ref_clk);
    chk_val(32'(timestamp != 32'h0), 32'h1, "unarmed sync");
    sync_n <= 1'b1;
    xfer(CMD_START_CAL, LEN_NONE, 32'h0, CMD_ACK, LEN_NONE, d);
    gyro_in <= 16'h0100;
    wait_tick(w);
    motion_count(cnt);
    chk_val({cnt, cal_busy}, {32'h0, 1'b1}, "calibrating");
    xfer(CMD_START_CAL, LEN_NONE, 32'h0, CMD_NACK, LEN_NONE, d);
    close_out();
  end
  // hang guard sized well past the expected run
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    close_out();
  end
endmodule : scs_ctrl_tb
